// ### include/smc_regs.svh
// Register map, field positions and timing constants for the sync mode configuration block
// Functional notes
// (R1) Preamble byte is sent repeatedly during preamble; write-only register resets to zero.
// (R2) Sync length clear: 6-bit mono or 12-bit bi; set: 8 or 16 bit.
// (R3) Bisync select clear: monosync, sync character from low sync register only.
// (R4) Bisync select set: bisync, sync character from low and high registers.
// (R5) In bisync the low sync part goes out first and is matched first.
// (R6) Receiver active bit gates reception: 0 holds receiver off, 1 runs it.
// (R7) Control bit 0: device raises request-to-send during transmission, drops when done.
// (R8) Control bit 1: request-to-send asserted at once until software clears it.
// (R9) Timer resolution bit: k is 32768 cycles when clear, 512 when set.
// (R10) Software writes zero to the two top bits of the mode register.
// (R11) Test loop bit connects each channel's transmitter output to its own receiver.
// (R12) Timer base period equals k times programmed value plus one clock periods.
// (R13) Mode bits: loop 0, resolution 1, rts 2, rx active 3, bisync 4, length 5.
`ifndef SMC_REGS_SVH
`define SMC_REGS_SVH
`define SMC_ADDR_PREAMBLE_A 8'h21
`define SMC_ADDR_MODE_A 8'h22
`define SMC_ADDR_SYNC_LO_A 8'h24
`define SMC_ADDR_SYNC_HI_A 8'h25
`define SMC_ADDR_TIMER_A 8'h23
`define SMC_ADDR_PREAMBLE_B 8'h61
`define SMC_ADDR_MODE_B 8'h62
`define SMC_ADDR_SYNC_LO_B 8'h64
`define SMC_ADDR_SYNC_HI_B 8'h65
`define SMC_ADDR_TIMER_B 8'h63
`define SMC_ADDR_STAT 8'h70
`define SMC_RST_BYTE 8'h00
`define SMC_BIT_LOOP 0
`define SMC_BIT_TIMER_RES 1
`define SMC_BIT_RTS 2
`define SMC_BIT_RX_ACTIVE 3
`define SMC_BIT_BIS 4
`define SMC_BIT_SYNC_LEN 5
`define SMC_MODE_MASK 8'h3F
`define SMC_K_SLOW 32768
`define SMC_K_FAST 512
`define SMC_TVAL_W 5
`endif

// ### include/smc_pkg.sv
// Types shared by the sync mode configuration block
package smc_pkg;
    typedef enum logic [2:0] {
        SMC_TX_IDLE = 3'h1,
        SMC_TX_PREAMBLE = 3'h2,
        SMC_TX_SYNC = 3'h4
    } smc_tx_state_t;
endpackage

// ### include/smc_chan_if.sv
// Per-channel configuration carried from the register bank to the channel engine
`timescale 1ns/1ps
`default_nettype none
interface smc_chan_if;
    logic [7:0] preamble;
    logic [7:0] mode;
    logic [7:0] sync_char_low;
    logic [7:0] sync_char_high;
    logic [4:0] timer_setting;
    logic tx_active;
    logic rts;
    logic rx_enable;
    logic loop;
    logic [16:0] k_factor;
    logic tick;
    modport bank (output preamble, mode, sync_char_low, sync_char_high, timer_setting,
        input rts, rx_enable, loop, k_factor, tick);
    modport chan (input preamble, mode, sync_char_low, sync_char_high, timer_setting, tx_active,
        output rts, rx_enable, loop, k_factor, tick);
endinterface
`default_nettype wire

// ### core/smc_chan.sv
// One channel: request-to-send, receiver gate, test loop and timer base period
`timescale 1ns/1ps
`default_nettype none
`include "smc_regs.svh"
module smc_chan (
    input wire logic i_mclk,
    input wire logic i_rst,
    smc_chan_if.chan cfg
);
    localparam logic [16:0] K_SLOW = 17'(`SMC_K_SLOW);
    localparam logic [16:0] K_FAST = 17'(`SMC_K_FAST);
    logic [21:0] cnt_q;
    logic [21:0] period;

    // ----------------------------------------
    // Modem and receiver controls
    // ----------------------------------------
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            cfg.rts <= 1'b0;
            cfg.rx_enable <= 1'b0;
            cfg.loop <= 1'b0;
        end
        else
        begin
            // Forced level wins, else follows transmission
            cfg.rts <= cfg.mode[`SMC_BIT_RTS] | cfg.tx_active; // see (R7) see (R8)
            cfg.rx_enable <= cfg.mode[`SMC_BIT_RX_ACTIVE]; // see (R6)
            cfg.loop <= cfg.mode[`SMC_BIT_LOOP]; // see (R11)
        end
    end

    // ----------------------------------------
    // Timer base period
    // ----------------------------------------
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            cfg.k_factor <= K_SLOW;
        else
            cfg.k_factor <= cfg.mode[`SMC_BIT_TIMER_RES] ? K_FAST : K_SLOW; // see (R9)
    end

    assign period = 22'(cfg.k_factor) * (22'(cfg.timer_setting) + 22'h000001); // see (R12)

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            cnt_q <= 22'h000000;
            cfg.tick <= 1'b0;
        end
        else if (cnt_q >= period - 22'h000001)
        begin
            cnt_q <= 22'h000000;
            cfg.tick <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 22'h000001;
            cfg.tick <= 1'b0;
        end
    end

    a_rts_forced: assert property (@(posedge i_mclk) disable iff (i_rst)
        cfg.mode[`SMC_BIT_RTS] |=> cfg.rts) // see (R8)
        else $error("rts not forced");
    a_rts_auto: assert property (@(posedge i_mclk) disable iff (i_rst)
        !cfg.mode[`SMC_BIT_RTS] && !cfg.tx_active |=> !cfg.rts) // see (R7)
        else $error("rts high without transmission");
    a_rx_gate: assert property (@(posedge i_mclk) disable iff (i_rst)
        1'b1 |=> cfg.rx_enable == $past(cfg.mode[`SMC_BIT_RX_ACTIVE])) // see (R6)
        else $error("receiver gate wrong");
    a_k_select: assert property (@(posedge i_mclk) disable iff (i_rst)
        cfg.mode[`SMC_BIT_TIMER_RES] |=> cfg.k_factor == K_FAST) // see (R9)
        else $error("k factor wrong");
    a_tick_count: assert property (@(posedge i_mclk) disable iff (i_rst)
        cfg.tick |-> cnt_q == 22'h000000) // see (R12)
        else $error("tick off count");
endmodule
`default_nettype wire

// ### core/smc_top.sv
// Two-channel sync mode configuration registers with preamble and sync serialiser
`timescale 1ns/1ps
`default_nettype none
`include "smc_regs.svh"
module smc_top (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic [1:0] i_tx_start,
    input wire logic [1:0] i_tx_preamble,
    input wire logic [1:0] i_tx_done,
    input wire logic [1:0] i_rxd,
    output logic [1:0] o_txd,
    output logic [1:0] o_rts,
    output logic [1:0] o_rx_bit,
    output logic [1:0] o_rx_valid,
    output logic [1:0] o_sync_hit,
    output logic [1:0] o_timer_tick
);
    logic [7:0] preamble_q [2];
    logic [7:0] mode_q [2];
    logic [7:0] sync_lo_q [2];
    logic [7:0] sync_hi_q [2];
    logic [4:0] timer_val_q [2];
    logic [1:0] busy_q;
    logic [1:0] rxs1_q;
    logic [1:0] rxs2_q;
    logic [7:0] rd_d;
    logic [15:0] hunt_q [2];
    smc_pkg::smc_tx_state_t st_q [2];
    logic [3:0] bit_q [2];
    smc_chan_if ch_if [2] ();

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            for (int c = 0; c < 2; c++)
            begin
                preamble_q[c] <= `SMC_RST_BYTE; // see (R1)
                mode_q[c] <= `SMC_RST_BYTE;
                sync_lo_q[c] <= `SMC_RST_BYTE;
                sync_hi_q[c] <= `SMC_RST_BYTE;
                timer_val_q[c] <= 5'h00;
            end
        end
        else if (i_wr)
        begin
            case (i_addr)
                `SMC_ADDR_PREAMBLE_A: preamble_q[0] <= i_wdata;
                `SMC_ADDR_PREAMBLE_B: preamble_q[1] <= i_wdata;
                // Top bits held at zero even if software slips
                `SMC_ADDR_MODE_A: mode_q[0] <= i_wdata & `SMC_MODE_MASK; // see (R10) see (R13)
                `SMC_ADDR_MODE_B: mode_q[1] <= i_wdata & `SMC_MODE_MASK; // see (R10) see (R13)
                `SMC_ADDR_SYNC_LO_A: sync_lo_q[0] <= i_wdata;
                `SMC_ADDR_SYNC_LO_B: sync_lo_q[1] <= i_wdata;
                `SMC_ADDR_SYNC_HI_A: sync_hi_q[0] <= i_wdata;
                `SMC_ADDR_SYNC_HI_B: sync_hi_q[1] <= i_wdata;
                `SMC_ADDR_TIMER_A: timer_val_q[0] <= i_wdata[`SMC_TVAL_W-1:0];
                `SMC_ADDR_TIMER_B: timer_val_q[1] <= i_wdata[`SMC_TVAL_W-1:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Register reads
    // ----------------------------------------
    always_comb
    begin
        rd_d = 8'h00;
        case (i_addr)
            // Preamble is write-only and reads zero
            `SMC_ADDR_MODE_A: rd_d = mode_q[0];
            `SMC_ADDR_MODE_B: rd_d = mode_q[1];
            `SMC_ADDR_SYNC_LO_A: rd_d = sync_lo_q[0];
            `SMC_ADDR_SYNC_LO_B: rd_d = sync_lo_q[1];
            `SMC_ADDR_SYNC_HI_A: rd_d = sync_hi_q[0];
            `SMC_ADDR_SYNC_HI_B: rd_d = sync_hi_q[1];
            `SMC_ADDR_TIMER_A: rd_d = {3'h0, timer_val_q[0]};
            `SMC_ADDR_TIMER_B: rd_d = {3'h0, timer_val_q[1]};
            `SMC_ADDR_STAT: rd_d = {2'h0, o_sync_hit, o_rts, busy_q};
            default: rd_d = 8'h00;
        endcase
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            o_rdata <= 8'h00;
        else if (i_rd)
            o_rdata <= rd_d;
        else
            o_rdata <= 8'h00;
    end

    // ----------------------------------------
    // Pin synchroniser
    // ----------------------------------------
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            rxs1_q <= 2'h0;
            rxs2_q <= 2'h0;
        end
        else
        begin
            rxs1_q <= i_rxd;
            rxs2_q <= rxs1_q;
        end
    end

    // ----------------------------------------
    // Per-channel engines
    // ----------------------------------------
    for (genvar c = 0; c < 2; c++)
    begin : g_ch
        logic rx_in;
        logic sync_length_sel;
        logic bis;
        logic [3:0] last_bit;
        logic [3:0] char_w;

        assign ch_if[c].preamble = preamble_q[c];
        assign ch_if[c].mode = mode_q[c];
        assign ch_if[c].sync_char_low = sync_lo_q[c];
        assign ch_if[c].sync_char_high = sync_hi_q[c];
        assign ch_if[c].timer_setting = timer_val_q[c];
        assign ch_if[c].tx_active = busy_q[c];

        smc_chan u_chan (
            .i_mclk(i_mclk),
            .i_rst(i_rst),
            .cfg(ch_if[c])
        );

        assign sync_length_sel = mode_q[c][`SMC_BIT_SYNC_LEN];
        assign bis = mode_q[c][`SMC_BIT_BIS];
        // Bits sent per sync unit: 6, 8, 12 or 16
        assign last_bit = bis ? (sync_length_sel ? 4'hF : 4'hB) : (sync_length_sel ? 4'h7 : 4'h5); // see (R2) see (R3) see (R4)
        // Bits taken from each sync register: 6 or 8
        assign char_w = sync_length_sel ? 4'h8 : 4'h6; // see (R2)
        // Looped data takes the unsynchronised path: it is already on this clock
        assign rx_in = ch_if[c].loop ? o_txd[c] : rxs2_q[c]; // see (R11)

        always_ff @(posedge i_mclk)
        begin
            if (i_rst)
            begin
                st_q[c] <= smc_pkg::SMC_TX_IDLE;
                bit_q[c] <= 4'h0;
                busy_q[c] <= 1'b0;
                o_txd[c] <= 1'b1;
            end
            else
            begin
                case (st_q[c])
                    smc_pkg::SMC_TX_IDLE:
                    begin
                        o_txd[c] <= 1'b1;
                        bit_q[c] <= 4'h0;
                        if (i_tx_start[c])
                        begin
                            busy_q[c] <= 1'b1; // see (R7)
                            st_q[c] <= i_tx_preamble[c] ? smc_pkg::SMC_TX_PREAMBLE : smc_pkg::SMC_TX_SYNC;
                        end
                    end
                    smc_pkg::SMC_TX_PREAMBLE:
                    begin
                        o_txd[c] <= preamble_q[c][3'(bit_q[c])]; // see (R1)
                        bit_q[c] <= (bit_q[c] == 4'h7) ? 4'h0 : bit_q[c] + 4'h1;
                        if (!i_tx_preamble[c] && bit_q[c] == 4'h7)
                            st_q[c] <= smc_pkg::SMC_TX_SYNC;
                    end
                    smc_pkg::SMC_TX_SYNC:
                    begin
                        // Low character bits first, then high, each lsb first
                        if (!bis || bit_q[c] < char_w)
                            o_txd[c] <= sync_lo_q[c][3'(bit_q[c])]; // see (R3) see (R5)
                        else
                            o_txd[c] <= sync_hi_q[c][3'(bit_q[c] - char_w)]; // see (R4)
                        bit_q[c] <= (bit_q[c] == last_bit) ? 4'h0 : bit_q[c] + 4'h1;
                        if (bit_q[c] == last_bit)
                        begin
                            st_q[c] <= smc_pkg::SMC_TX_IDLE;
                            busy_q[c] <= 1'b0; // see (R7)
                        end
                    end
                    default:
                    begin
                        st_q[c] <= smc_pkg::SMC_TX_IDLE;
                        busy_q[c] <= 1'b0;
                    end
                endcase
                if (i_tx_done[c])
                begin
                    st_q[c] <= smc_pkg::SMC_TX_IDLE;
                    busy_q[c] <= 1'b0;
                end
            end
        end

        always_ff @(posedge i_mclk)
        begin
            if (i_rst)
            begin
                hunt_q[c] <= 16'h0000;
                o_rx_bit[c] <= 1'b0;
                o_rx_valid[c] <= 1'b0;
                o_sync_hit[c] <= 1'b0;
                o_rts[c] <= 1'b0;
                o_timer_tick[c] <= 1'b0;
            end
            else
            begin
                o_rts[c] <= ch_if[c].rts;
                o_timer_tick[c] <= ch_if[c].tick;
                o_rx_valid[c] <= ch_if[c].rx_enable; // see (R6)
                o_rx_bit[c] <= ch_if[c].rx_enable & rx_in;
                if (ch_if[c].rx_enable)
                    hunt_q[c] <= {hunt_q[c][14:0], rx_in}; // see (R6)
                o_sync_hit[c] <= ch_if[c].rx_enable &&
                    sync_match(hunt_q[c], sync_lo_q[c], sync_hi_q[c], last_bit, char_w); // see (R3) see (R4) see (R5)
            end
        end
    end

    // Line order is low part first, lsb first; the oldest received bit sits at hunt bit lb
    function automatic logic sync_match(input logic [15:0] h, input logic [7:0] lo, input logic [7:0] hi,
        input logic [3:0] lb, input logic [3:0] w);
        logic ok;
        logic [3:0] k;
        ok = 1'b1;
        for (int i = 0; i < 16; i++)
        begin
            k = 4'(i);
            if (k <= lb)
            begin
                if (k < w)
                    ok = ok & (h[lb - k] == lo[3'(k)]);
                else
                    ok = ok & (h[lb - k] == hi[3'(k - w)]);
            end
        end
        return ok;
    endfunction

    a_mode_top_zero: assert property (@(posedge i_mclk) disable iff (i_rst)
        mode_q[0][7:6] == 2'h0 && mode_q[1][7:6] == 2'h0) // see (R10)
        else $error("mode top bits set");
    a_pre_writeonly: assert property (@(posedge i_mclk) disable iff (i_rst)
        i_rd && i_addr == `SMC_ADDR_PREAMBLE_A |=> o_rdata == 8'h00) // see (R1)
        else $error("preamble readable");
    a_rts_to_pin: assert property (@(posedge i_mclk) disable iff (i_rst)
        mode_q[0][`SMC_BIT_RTS] |-> ##2 o_rts[0]) // see (R8)
        else $error("rts pin not forced");

    // A sync unit launched from idle puts the low register's first bit on the line
    sequence s_sync_launch;
        st_q[0] == smc_pkg::SMC_TX_IDLE && i_tx_start[0] && !i_tx_preamble[0] && !i_tx_done[0];
    endsequence
    sequence s_low_first;
        ##2 o_txd[0] == $past(sync_lo_q[0][0]);
    endsequence
    a_sync_low_first: assert property (@(posedge i_mclk) disable iff (i_rst)
        s_sync_launch |-> s_low_first) // see (R5)
        else $error("sync low part not first");
endmodule
`default_nettype wire

// ### tb/smc_line_model.sv
// Far-end serial line model that feeds the receive pins
`timescale 1ns/1ps
`default_nettype none
module smc_line_model (
    input wire logic i_mclk,
    input wire logic i_rst,
    output logic [1:0] o_rxd = 2'h1
);
    // A line that changes every cycle, so a receiver that ignores it cannot pass
    always @(posedge i_mclk)
    begin
        o_rxd <= i_rst ? 2'h1 : ~o_rxd;
    end
endmodule
`default_nettype wire

// ### tb/tb_smc_top.sv
// Self-checking bench for the sync mode configuration registers
`timescale 1ns/1ps
`default_nettype none
module tb_smc_top;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [1:0] i_tx_start = 2'h0;
    logic [1:0] i_tx_preamble = 2'h0;
    logic [1:0] i_tx_done = 2'h0;
    logic [1:0] i_rxd;
    logic [7:0] o_rdata;
    logic [1:0] o_txd, o_rts, o_rx_bit, o_rx_valid, o_sync_hit, o_timer_tick;
    logic [31:0] rng = 32'h0000004A;
    int num_errors = 0;
    int checks_done = 0;
    smc_top uut (.i_mclk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_tx_start, .i_tx_preamble,
        .i_tx_done, .i_rxd, .o_txd, .o_rts, .o_rx_bit, .o_rx_valid, .o_sync_hit, .o_timer_tick);
    smc_line_model line (.i_mclk(i_mclk), .i_rst(i_rst), .o_rxd(i_rxd));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [7:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng[7:0];
    endfunction
    // Bits on the line, first sent in bit 0; unused tail stays idle high
    function automatic logic [15:0] sync_bits(input logic [7:0] m, input logic [7:0] lo, input logic [7:0] hi);
        logic [15:0] v;
        v = 16'hFFFF;
        if (m[5])
            v[7:0] = lo;
        else
            v[5:0] = lo[5:0];
        if (m[4] && m[5])
            v[15:8] = hi;
        else if (m[4])
            v[11:6] = hi[5:0];
        return v;
    endfunction
    function automatic logic pick(input int sel, input int ch);
        case (sel)
            0: return o_rts[ch];
            1: return o_txd[ch];
            2: return o_timer_tick[ch];
            4: return o_sync_hit[ch];
            default: return o_rx_bit[ch];
        endcase
    endfunction
    // Sync unit length in bits for a mode byte
    function automatic int sync_len(input logic [7:0] m);
        return m[4] ? (m[5] ? 16 : 12) : (m[5] ? 8 : 6);
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        #1;
    endtask
    task automatic chk_rd(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_mclk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1;
        check(what, o_rdata, exp);
    endtask
    task automatic drive(input int sel, input int ch, input logic v);
        @(posedge i_mclk);
        case (sel)
            0: i_tx_start[ch] <= v;
            1: i_tx_done[ch] <= v;
            default: i_tx_preamble[ch] <= v;
        endcase
        #1;
    endtask
    task automatic pulse(input int sel, input int ch);
        drive(sel, ch, 1'b1);
        drive(sel, ch, 1'b0);
    endtask
    // Bounded wait; running out of cycles ends the run
    task automatic wait_on(input string what, input int sel, input int ch, input logic lvl, input int lim,
        output int n);
        n = 0;
        while (pick(sel, ch) !== lvl)
        begin
            if (n >= lim)
            begin
                check(what, 16'h0000, 16'h0001);
                finish_test();
            end
            cyc(1);
            n++;
        end
    endtask
    task automatic grab(input int sel, input int ch, input int len, output logic [15:0] v);
        v = 16'hFFFF;
        for (int k = 0; k < len; k++)
        begin
            v[k] = pick(sel, ch);
            cyc(1);
        end
    endtask
    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial
    begin
        forever #25 i_mclk = ~i_mclk;
    end
    initial
    begin
        #5000000;
        check("run time", 16'h0000, 16'h0001);
        finish_test();
    end
    initial
    begin
        logic [7:0] b, m, lo, hi;
        logic [15:0] v;
        logic [7:0] modes [4];
        int n, ch;
        modes = '{8'h00, 8'h20, 8'h10, 8'h30};
        repeat (10) @(posedge i_mclk);
        i_rst <= 1'b0;
        for (ch = 0; ch < 2; ch++)
        begin
            b = ch ? 8'h60 : 8'h20;
            chk_rd("preamble reset", b + 8'h01, 8'h00);
            chk_rd("mode reset", b + 8'h02, 8'h00);
        end
        chk_rd("unmapped read", 8'h40, 8'h00);
        $display("test reset values done");
        repeat (16)
        begin
            ch = int'(rnd() & 8'h01);
            b = ch ? 8'h60 : 8'h20;
            m = rnd();
            wr(b + 8'h02, m & 8'h3F);
            wr(b + 8'h01, rnd());
            chk_rd("mode readback", b + 8'h02, m & 8'h3F);
            chk_rd("preamble write-only", b + 8'h01, 8'h00);
        end
        wr(8'h22, 8'hFF);
        chk_rd("mode unused bits", 8'h22, 8'h3F);
        wr(8'h40, 8'h5A);
        chk_rd("unmapped write", 8'h40, 8'h00);
        wr(8'h22, 8'h00);
        wr(8'h62, 8'h00);
        $display("test register access done");
        for (ch = 0; ch < 2; ch++)
        begin
            b = ch ? 8'h60 : 8'h20;
            wr(b + 8'h02, 8'h04);
            wait_on("rts forced", 0, ch, 1'b1, 4, n);
            cyc(20);
            check("rts held", o_rts[ch], 1'b1);
            check("other rts", o_rts[1 - ch], 1'b0);
            wr(b + 8'h02, 8'h00);
            wait_on("rts released", 0, ch, 1'b0, 4, n);
            pulse(0, ch);
            wait_on("rts auto on", 0, ch, 1'b1, 4, n);
            pulse(1, ch);
            wait_on("rts auto off", 0, ch, 1'b0, 20, n);
            cyc(4);
            check("rx gated valid", o_rx_valid[ch], 1'b0);
            check("rx gated bit", o_rx_bit[ch], 1'b0);
            wr(b + 8'h02, 8'h08);
            cyc(4);
            check("rx active", o_rx_valid[ch], 1'b1);
            grab(3, ch, 8, v);
            check("rx follows line", v[7:0] == 8'h55 || v[7:0] == 8'hAA, 1'b1);
            wr(b + 8'h02, 8'h09);
            cyc(4);
            grab(3, ch, 8, v);
            check("loop idle", v[7:0], 8'hFF);
            wr(b + 8'h03, 8'(ch * 3));
            wr(b + 8'h02, 8'h02);
            wait_on("first tick", 2, ch, 1'b1, 2100, n);
            cyc(1);
            check("tick width", o_timer_tick[ch], 1'b0);
            wait_on("next tick", 2, ch, 1'b1, 2100, n);
            check("tick period", 16'(n + 1), 16'(512 * (ch * 3 + 1)));
            wr(b + 8'h02, 8'h00);
            n = 0;
            repeat (1100)
            begin
                cyc(1);
                if (o_timer_tick[ch] !== 1'b0)
                    n++;
            end
            check("slow resolution", 16'(n), 16'h0000);
        end
        $display("test rts receiver timer done");
        for (int i = 0; i < 10; i++)
        begin
            ch = i & 1;
            b = ch ? 8'h60 : 8'h20;
            m = modes[(i >> 1) & 3];
            lo = rnd() & 8'hFE;
            hi = rnd();
            wr(b + 8'h04, lo);
            wr(b + 8'h05, hi);
            wr(b + 8'h01, lo);
            wr(b + 8'h02, m);
            if (i > 7)
                drive(2, ch, 1'b1);
            pulse(0, ch);
            wait_on("line start", 1, ch, 1'b0, 8, n);
            grab(1, ch, 16, v);
            if (i > 7)
                check("preamble bits", v, {lo, lo});
            else
                check("sync bits", v, sync_bits(m, lo, hi));
            drive(2, ch, 1'b0);
            pulse(1, ch);
            cyc(20);
        end
        $display("test serialiser done");
        // Looped sync unit must be found by the hunt for a single cycle, right after its last bit
        for (int i = 0; i < 4; i++)
        begin
            ch = i & 1;
            b = ch ? 8'h60 : 8'h20;
            m = modes[i] | 8'h09;
            lo = rnd() & 8'hFE;
            hi = rnd();
            wr(b + 8'h04, lo);
            wr(b + 8'h05, hi);
            wr(b + 8'h02, m);
            cyc(20);
            pulse(0, ch);
            wait_on("sync hit", 4, ch, 1'b1, 40, n);
            check("sync hit time", 16'(n), 16'(sync_len(m) + 2));
            cyc(1);
            check("sync hit width", o_sync_hit[ch], 1'b0);
            wr(b + 8'h02, 8'h00);
        end
        $display("test sync hunt done");
        finish_test();
    end
endmodule
`default_nettype wire
